// ### core/opc_output_path.sv
// Output path control register bank, page 1 offsets 0x08 to 0x0F,
// with the page select register and over-current debounce logic.
// Assumes a simple synchronous register port and a synchronous
// over-current detect level from the analog headphone driver.
//
// Behaviour
// - Gain-step bit 7 high disables soft-stepping of all gain stages.
// - Gain-step bit 6 high doubles soft-stepping time of all gain stages.
// - Power bit 5 powers the headphone output; resets to zero.
// - Power bit 1 enables the left analog input; resets to zero.
// - Power bit 0 enables the right analog input; resets to zero.
// - Common-mode bit 6 selects 0.75V when high, 0.9V when low.
// - Common-mode bit 2 high gives half headphone drive, else full.
// - Debounce field 3:1: zero means none, else 8ms doubling to 512ms.
// - Over-current bit 0: low limits current, high powers driver down.
// - Routing field 7:4 selects one analog route; unused codes route nothing.
// - Routing bit 3 connects converter output straight to headphone driver.
// - Routing bit 2 connects mixer P to the headphone attenuator.
// - Routing bit 1 routes left-input attenuator to headphone driver.
// - Routing bit 0 routes right-input attenuator to headphone driver.
// - Offset 0 selects the page; this bank answers only on page 1.
`timescale 1ns/1ps
`default_nettype none
`include "opc_regs.svh"

module opc_output_path
  import opc_pkg::*;
#(
  parameter int unsigned DEB_BASE_CYC = `OPC_DEB_BASE_CYC
)(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       oc_detect,
  output logic            softstep_disable,
  output logic            softstep_double,
  output logic            headphone_output_on,
  output logic            left_analog_input_en,
  output logic            right_analog_input_en,
  output logic            common_mode_low,
  output logic            headphone_half_drive,
  output logic            right_to_mixer_p,
  output logic            left_to_mixer_a,
  output logic            both_to_headphone_driver,
  output logic            diff_to_speaker_driver,
  output logic            converter_to_headphone,
  output logic            mixer_p_to_attenuator,
  output logic            left_atten_to_headphone,
  output logic            right_atten_to_headphone,
  output logic            headphone_current_limit,
  output logic            headphone_fault_off
);

  // All assertions below run on mclk and rest during reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (DEB_BASE_CYC < 1 || (64'(DEB_BASE_CYC) << 6) >= (64'd1 << `OPC_CNT_W))
  begin : g_bad_base
    $error("debounce base count does not fit the counter");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Cycles the detect must persist for a nonzero debounce code
  function automatic logic [`OPC_CNT_W-1:0] deb_limit(input logic [2:0] code);
    logic [`OPC_CNT_W-1:0] base;
    base = `OPC_CNT_W'(DEB_BASE_CYC);
    return base << (code - 3'h1);
  endfunction

  function automatic logic bank_hit(input logic [7:0] p, input logic [7:0] a,
                                    input logic [7:0] off);
    return (p == `OPC_BANK_PAGE) && (a == off);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  opc_state_s st;
  opc_state_s next_st;
  logic [7:0] rd_val;
  logic       oc_due;

  always_comb
  begin
    next_st = st;
    rd_val  = 8'h00;
    oc_due  = 1'b0;

    // Page select lives at offset 0 of every page
    if (wr && addr == `OPC_OFF_PAGE)
    begin
      next_st.page = wdata;
    end
    // Only writable bits are stored; reserved bits stay zero
    if (wr && bank_hit(st.page, addr, `OPC_OFF_GAIN))
    begin
      next_st.ss_dis = wdata[`OPC_B_SS_DIS];
      next_st.ss_dbl = wdata[`OPC_B_SS_DBL];
    end
    if (wr && bank_hit(st.page, addr, `OPC_OFF_POWER))
    begin
      next_st.hp_pwr = wdata[`OPC_B_HP_PWR];
      next_st.left_analog_input   = wdata[`OPC_B_LEFT_ANALOG_INPUT];
      next_st.right_analog_input   = wdata[`OPC_B_RIGHT_ANALOG_INPUT];
    end
    if (wr && bank_hit(st.page, addr, `OPC_OFF_CMODE))
    begin
      next_st.cm_low   = wdata[`OPC_B_CM_LOW];
      next_st.half_drv = wdata[`OPC_B_HALF_DRV];
    end
    // Bit 4 is stored as written, so a stray zero shows on readback
    if (wr && bank_hit(st.page, addr, `OPC_OFF_OCCFG))
    begin
      next_st.oc_keep = wdata[`OPC_B_OC_KEEP];
      next_st.oc_deb  = wdata[`OPC_F_OC_DEB_HI:`OPC_F_OC_DEB_LO];
      next_st.oc_off  = wdata[`OPC_B_OC_OFF];
    end
    if (wr && bank_hit(st.page, addr, `OPC_OFF_ROUTE))
    begin
      next_st.route    = wdata[`OPC_F_ROUTE_HI:`OPC_F_ROUTE_LO];
      next_st.dac_hp   = wdata[`OPC_B_DAC_HP];
      next_st.mixp_att = wdata[`OPC_B_MIXP_ATT];
      next_st.l_att    = wdata[`OPC_B_L_ATT];
      next_st.r_att    = wdata[`OPC_B_R_ATT];
    end

    // Route decode; unused codes route nothing
    next_st.r_to_mixp  = 1'b0;
    next_st.l_to_mixa  = 1'b0;
    next_st.lr_to_hp   = 1'b0;
    next_st.dif_to_spk = 1'b0;
    unique case (next_st.route)
      OPC_RT_R_P:   next_st.r_to_mixp  = 1'b1;
      OPC_RT_L_A:   next_st.l_to_mixa  = 1'b1;
      OPC_RT_LR_HP: next_st.lr_to_hp   = 1'b1;
      OPC_RT_DIF_A,
      OPC_RT_DIF_B: next_st.dif_to_spk = 1'b1;
      default:      next_st.dif_to_spk = 1'b0;
    endcase

    // Persistence counter, saturating, cleared when detect drops
    if (!oc_detect)
    begin
      next_st.oc_cnt = '0;
    end
    else if (st.oc_cnt != '1)
    begin
      next_st.oc_cnt = st.oc_cnt + `OPC_CNT_W'(1);
    end
    // Zero code acts at once, others after the doubling time
    oc_due = oc_detect && (st.oc_deb == 3'h0 || next_st.oc_cnt >= deb_limit(st.oc_deb));

    // Limit current while due, or latch a driver shutdown
    next_st.oc_limit = oc_due && !st.oc_off;
    // Shutdown holds until software clears the power bit; set wins
    if (oc_due && st.oc_off)
    begin
      next_st.oc_shut = 1'b1;
    end
    else if (!next_st.hp_pwr)
    begin
      next_st.oc_shut = 1'b0;
    end
    next_st.hp_on = next_st.hp_pwr && !next_st.oc_shut;

    // Read path; reserved bits and offsets read zero
    if (addr == `OPC_OFF_PAGE)
    begin
      rd_val = st.page;
    end
    else if (bank_hit(st.page, addr, `OPC_OFF_GAIN))
    begin
      rd_val = {st.ss_dis, st.ss_dbl, 6'h00};
    end
    else if (bank_hit(st.page, addr, `OPC_OFF_POWER))
    begin
      rd_val = {2'h0, st.hp_pwr, 3'h0, st.left_analog_input, st.right_analog_input};
    end
    else if (bank_hit(st.page, addr, `OPC_OFF_CMODE))
    begin
      rd_val = {1'b0, st.cm_low, 3'h0, st.half_drv, 2'h0};
    end
    else if (bank_hit(st.page, addr, `OPC_OFF_OCCFG))
    begin
      rd_val = {3'h0, st.oc_keep, st.oc_deb, st.oc_off};
    end
    else if (bank_hit(st.page, addr, `OPC_OFF_ROUTE))
    begin
      rd_val = {st.route, st.dac_hp, st.mixp_att, st.l_att, st.r_att};
    end
    next_st.rdata = rd ? rd_val : 8'h00;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st         <= '0;
      st.page    <= `OPC_PAGE_RST;
      st.oc_keep <= 1'(`OPC_OCCFG_RST >> `OPC_B_OC_KEEP);
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata                    = st.rdata;
  assign softstep_disable         = st.ss_dis;
  assign softstep_double          = st.ss_dbl;
  assign headphone_output_on      = st.hp_on;
  assign left_analog_input_en     = st.left_analog_input;
  assign right_analog_input_en    = st.right_analog_input;
  assign common_mode_low          = st.cm_low;
  assign headphone_half_drive     = st.half_drv;
  assign right_to_mixer_p         = st.r_to_mixp;
  assign left_to_mixer_a          = st.l_to_mixa;
  assign both_to_headphone_driver = st.lr_to_hp;
  assign diff_to_speaker_driver   = st.dif_to_spk;
  assign converter_to_headphone   = st.dac_hp;
  assign mixer_p_to_attenuator    = st.mixp_att;
  assign left_atten_to_headphone  = st.l_att;
  assign right_atten_to_headphone = st.r_att;
  assign headphone_current_limit  = st.oc_limit;
  assign headphone_fault_off      = st.oc_shut;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------

  a_page_write: assert property (
    wr && addr == `OPC_OFF_PAGE |=> st.page == $past(wdata))
    else $error("page select not taken");

  a_softstep_write: assert property (
    wr && st.page == `OPC_BANK_PAGE && addr == `OPC_OFF_GAIN
    |=> softstep_disable == $past(wdata[7]) && softstep_double == $past(wdata[6]))
    else $error("gain-step bits not applied");

  a_power_write: assert property (
    wr && st.page == `OPC_BANK_PAGE && addr == `OPC_OFF_POWER
    |=> left_analog_input_en == $past(wdata[`OPC_B_LEFT_ANALOG_INPUT])
        && right_analog_input_en == $past(wdata[`OPC_B_RIGHT_ANALOG_INPUT]))
    else $error("input enable bits not applied");

  a_hp_power_down: assert property (
    wr && st.page == `OPC_BANK_PAGE && addr == `OPC_OFF_POWER && !wdata[`OPC_B_HP_PWR]
    |=> !headphone_output_on)
    else $error("headphone output on after power down");

  a_cmode_write: assert property (
    wr && st.page == `OPC_BANK_PAGE && addr == `OPC_OFF_CMODE
    |=> common_mode_low == $past(wdata[`OPC_B_CM_LOW])
        && headphone_half_drive == $past(wdata[`OPC_B_HALF_DRV]))
    else $error("common-mode bits not applied");

  a_route_bits: assert property (
    wr && st.page == `OPC_BANK_PAGE && addr == `OPC_OFF_ROUTE
    |=> converter_to_headphone == $past(wdata[`OPC_B_DAC_HP])
        && mixer_p_to_attenuator == $past(wdata[`OPC_B_MIXP_ATT])
        && left_atten_to_headphone == $past(wdata[`OPC_B_L_ATT])
        && right_atten_to_headphone == $past(wdata[`OPC_B_R_ATT]))
    else $error("routing bits not applied");

  a_other_page: assert property (
    wr && st.page != `OPC_BANK_PAGE && addr == `OPC_OFF_POWER
    |=> $stable(left_analog_input_en) && $stable(right_analog_input_en))
    else $error("bank written from another page");

  a_reserved_read: assert property (
    rd && addr >= `OPC_OFF_RSVD_LO && addr <= `OPC_OFF_RSVD_HI |=> rdata == 8'h00)
    else $error("reserved offset read nonzero");

  a_rdata_idle: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data outside read answer");

  a_route_onehot: assert property (
    $onehot0({right_to_mixer_p, left_to_mixer_a, both_to_headphone_driver,
              diff_to_speaker_driver})
    && (st.route == 4'hC) == both_to_headphone_driver)
    else $error("route decode wrong");

  a_oc_immediate: assert property (
    st.oc_deb == 3'h0 && !st.oc_off && oc_detect |=> headphone_current_limit)
    else $error("undebounced limit late");

  a_oc_persist: assert property (
    headphone_current_limit && $past(st.oc_deb) != 3'h0
    |-> $past(st.oc_cnt) + 1 >= deb_limit($past(st.oc_deb)))
    else $error("over-current acted before debounce");

  a_oc_shutdown: assert property (
    headphone_fault_off |-> !headphone_output_on && !headphone_current_limit)
    else $error("driver on during shutdown");

endmodule
`default_nettype wire

// ### common/opc_regs.svh
// Offsets, field positions, reset values and timing counts of the
// output path control bank; included by the package and the core.
`ifndef OPC_REGS_SVH
`define OPC_REGS_SVH

`define OPC_ADDR_W        8
`define OPC_DATA_W        8
`define OPC_OFF_PAGE      8'h00
`define OPC_OFF_GAIN      8'h08
`define OPC_OFF_POWER     8'h09
`define OPC_OFF_CMODE     8'h0A
`define OPC_OFF_OCCFG     8'h0B
`define OPC_OFF_ROUTE     8'h0C
`define OPC_OFF_RSVD_LO   8'h0D
`define OPC_OFF_RSVD_HI   8'h0F
`define OPC_BANK_PAGE     8'h01
`define OPC_PAGE_RST      8'h00
`define OPC_OCCFG_RST     8'h10

`define OPC_B_SS_DIS      7
`define OPC_B_SS_DBL      6
`define OPC_B_HP_PWR      5
`define OPC_B_LEFT_ANALOG_INPUT        1
`define OPC_B_RIGHT_ANALOG_INPUT        0
`define OPC_B_CM_LOW      6
`define OPC_B_HALF_DRV    2
`define OPC_B_OC_KEEP     4
`define OPC_F_OC_DEB_HI   3
`define OPC_F_OC_DEB_LO   1
`define OPC_B_OC_OFF      0
`define OPC_F_ROUTE_HI    7
`define OPC_F_ROUTE_LO    4
`define OPC_B_DAC_HP      3
`define OPC_B_MIXP_ATT    2
`define OPC_B_L_ATT       1
`define OPC_B_R_ATT       0

`define OPC_CLK_PERIOD_NS 100
`define OPC_DEB_BASE_MS   8
`define OPC_DEB_BASE_CYC  (`OPC_DEB_BASE_MS * 1000000 / `OPC_CLK_PERIOD_NS)
`define OPC_CNT_W         24

`endif

// ### common/opc_pkg.sv
// Types of the output path control bank.
// Assumes opc_regs.svh is on the include path.
`default_nettype none
`include "opc_regs.svh"

package opc_pkg;

  typedef enum logic [3:0] {
    OPC_RT_NONE  = 4'h0,
    OPC_RT_R_P   = 4'h4,
    OPC_RT_DIF_A = 4'h6,
    OPC_RT_L_A   = 4'h8,
    OPC_RT_DIF_B = 4'h9,
    OPC_RT_LR_HP = 4'hC
  } opc_route_e;

  typedef struct packed {
    logic [7:0]             page;
    logic                   ss_dis;
    logic                   ss_dbl;
    logic                   hp_pwr;
    logic                   left_analog_input;
    logic                   right_analog_input;
    logic                   cm_low;
    logic                   half_drv;
    logic                   oc_keep;
    logic [2:0]             oc_deb;
    logic                   oc_off;
    logic [3:0]             route;
    logic                   dac_hp;
    logic                   mixp_att;
    logic                   l_att;
    logic                   r_att;
    logic                   r_to_mixp;
    logic                   l_to_mixa;
    logic                   lr_to_hp;
    logic                   dif_to_spk;
    logic                   hp_on;
    logic [`OPC_CNT_W-1:0]  oc_cnt;
    logic                   oc_limit;
    logic                   oc_shut;
    logic [7:0]             rdata;
  } opc_state_s;

endpackage
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the output path control register bank.
// Assumes opc_pkg and opc_output_path are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import opc_pkg::*;

  // Short debounce base so the longest code stays at a few hundred cycles
  localparam int DEB = 4;

  logic       mclk      = 1'b0;
  logic       rst       = 1'b1;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic       oc_detect = 1'b0;
  logic [7:0] rdata;
  wire logic [6:0] ctl;
  wire logic [7:0] rte;
  wire logic [1:0] oc;
  int         bad_count  = 0;
  int         num_checks = 0;

  opc_output_path #(.DEB_BASE_CYC(DEB)) opc_output_path_i (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .oc_detect(oc_detect), .softstep_disable(ctl[6]), .softstep_double(ctl[5]),
    .headphone_output_on(ctl[4]), .left_analog_input_en(ctl[3]), .right_analog_input_en(ctl[2]),
    .common_mode_low(ctl[1]), .headphone_half_drive(ctl[0]), .right_to_mixer_p(rte[7]),
    .left_to_mixer_a(rte[6]), .both_to_headphone_driver(rte[5]), .diff_to_speaker_driver(rte[4]),
    .converter_to_headphone(rte[3]), .mixer_p_to_attenuator(rte[2]),
    .left_atten_to_headphone(rte[1]), .right_atten_to_headphone(rte[0]),
    .headphone_current_limit(oc[1]), .headphone_fault_off(oc[0])
  );

  always #50 mclk = ~mclk;

  // ----------------------------------------
  // Register port tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, e);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] v;
    logic [7:0] g;
    logic [7:0] p;
    logic [7:0] c;
    logic [7:0] rv [8];
    logic [7:0] msk [3];
    logic [7:0] unm [5];
    int         n;
    rv  = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    msk = '{8'hC0, 8'h23, 8'h44};
    unm = '{8'h0D, 8'h0E, 8'h0F, 8'h05, 8'h10};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("ctl reset", ctl, 7'h00);
    check("route reset", rte, 8'h00);
    check("oc reset", oc, 2'b00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h0B, 8'h00);
    wr_reg(8'h00, 8'h01);
    rd_chk(8'h00, 8'h01);
    for (int i = 0; i < 8; i++)
      rd_chk(8'(8 + i), rv[i]);
    // Walking one across the three plain control registers
    for (int i = 0; i < 3; i++)
      for (int b = 0; b < 8; b++)
      begin
        v = 8'h01 << b;
        g = (i == 0) ? v : 8'h00;
        p = (i == 1) ? v : 8'h00;
        c = (i == 2) ? v : 8'h00;
        wr_reg(8'(8 + i), v);
        rd_chk(8'(8 + i), v & msk[i]);
        check("ctl", ctl, {g[7], g[6], p[5], p[1], p[0], c[6], c[2]});
        wr_reg(8'(8 + i), 8'h00);
      end
    wr_reg(8'h0B, 8'hFF);
    rd_chk(8'h0B, 8'h1F);
    wr_reg(8'h0B, 8'h10);
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(unm[i], 8'hFF);
      rd_chk(unm[i], 8'h00);
    end
    // Every routing code, unused ones included, with the low bits varied
    for (int k = 0; k < 16; k++)
    begin
      v = {k[3:0], ~k[3:0]};
      wr_reg(8'h0C, v);
      rd_chk(8'h0C, v);
      check("route", rte, {k == 4, k == 8, k == 12, k == 6 || k == 9, ~k[3:0]});
    end
    wr_reg(8'h09, 8'h23);
    wr_reg(8'h00, 8'h02);
    wr_reg(8'h09, 8'h00);
    rd_chk(8'h09, 8'h00);
    wr_reg(8'h00, 8'h01);
    rd_chk(8'h09, 8'h23);
    check("ctl page", ctl, 7'h1C);
    // Debounce: limit must not rise one sample early, and must rise on time
    for (int k = 0; k < 8; k++)
    begin
      n = (k == 0) ? 1 : DEB << (k - 1);
      wr_reg(8'h0B, 8'(8'h10 | (k << 1)));
      @(posedge mclk);
      oc_detect <= 1'b1;
      repeat (n - 1) @(posedge mclk);
      #1;
      check("limit early", oc, 2'b00);
      @(posedge mclk);
      #1;
      check("limit", oc, 2'b10);
      check("hp on limit", ctl[4], 1'b1);
      @(posedge mclk);
      oc_detect <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check("limit off", oc, 2'b00);
    end
    // Shutdown response latches until software powers the driver down
    wr_reg(8'h0B, 8'h11);
    @(posedge mclk);
    oc_detect <= 1'b1;
    @(posedge mclk);
    oc_detect <= 1'b0;
    #1;
    check("fault", oc, 2'b01);
    repeat (3) @(posedge mclk);
    #1;
    check("fault held", oc, 2'b01);
    check("hp off", ctl[4], 1'b0);
    wr_reg(8'h09, 8'h03);
    wr_reg(8'h09, 8'h23);
    check("fault clear", oc, 2'b00);
    check("ctl restored", ctl, 7'h1C);
    // Mid-run reset must bring every written field back to its reset value
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("ctl rerst", ctl, 7'h00);
    check("oc rerst", oc, 2'h0);
    rd_chk(8'h00, 8'h00);
    wr_reg(8'h00, 8'h01);
    rd_chk(8'h0B, 8'h10);
    rd_chk(8'h0C, 8'h00);
    results();
  end

  // Run needs under a thousand cycles; allow about twenty thousand
  initial
  begin
    #(100 * 20000);
    bad_count++;
    results();
  end

endmodule

`default_nettype wire
